// ---- ibb_map.svh ----
`ifndef IBB_MAP_SVH
`define IBB_MAP_SVH

// Register addresses (16-bit configuration space)
`define IBB_ADDR_A_CTL1      16'h0806
`define IBB_ADDR_A_CTL2      16'h0807
`define IBB_ADDR_B_CTL1      16'h0808
`define IBB_ADDR_B_CTL2      16'h0809
`define IBB_ADDR_SENSE_PD    16'h082D
`define IBB_ADDR_A_PD        16'h082F

// Reset value of every register
`define IBB_REG_RESET        8'h00

// First control register fields
`define IBB_POL_BIT          7
`define IBB_MODE_BIT         6
`define IBB_RATE_MSB         5
`define IBB_RATE_LSB         0

// Second control register fields
`define IBB_TAIL_MSB         7
`define IBB_TAIL_LSB         2
`define IBB_RUN_BIT          1
`define IBB_PADSEL_BIT       0

// Pull-down register widths
`define IBB_SENSE_PD_W       5
`define IBB_A_PD_W           1

// Timing
`define IBB_CLK_HZ           200000000
`define IBB_TICK_MS          50
`define IBB_TICK_CYCLES      ((`IBB_CLK_HZ / 1000) * `IBB_TICK_MS)
`define IBB_BREATH_TICKS     10

`endif

// ---- ibb_pkg.sv ----
package ibb_pkg;

    typedef enum logic [3:0] {
        IBB_IDLE    = 4'b0001,
        IBB_ACTIVE  = 4'b0010,
        IBB_TAIL    = 4'b0100,
        IBB_SLEEP   = 4'b1000
    } ibb_state_t;

endpackage : ibb_pkg

// ---- ibb_prescaler.sv ----
`timescale 1ns/1ps
`include "ibb_map.svh"

module ibb_prescaler #(
    parameter int unsigned TICK_CYCLES = `IBB_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    // Timebase
    output logic      tick
);

    logic [31:0] count_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 32'h0000_0000;
            tick      <= 1'b0;
        end else if (clk_en) begin
            if (count_reg >= TICK_CYCLES - 1) begin
                count_reg <= 32'h0000_0000;
                tick      <= 1'b1;
            end else begin
                count_reg <= count_reg + 32'h0000_0001;
                tick      <= 1'b0;
            end
        end
    end

endmodule : ibb_prescaler

// ---- ibb_channel.sv ----
`timescale 1ns/1ps
`include "ibb_map.svh"

module ibb_channel (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // Timebase
    input  wire logic       tick,
    // Controls
    input  wire logic       breathe,
    input  wire logic       invert,
    input  wire logic       run,
    input  wire logic [5:0] rate,
    input  wire logic [5:0] tail,
    // Pattern
    output logic            pattern,
    output logic            busy
);

    ibb_pkg::ibb_state_t state_reg;
    logic        run_d_reg;
    logic        first_reg;
    logic [9:0]  period_reg;
    logic [9:0]  tail_reg;
    logic [7:0]  pwm_reg;
    logic [9:0]  half_len;
    logic [17:0] prod;
    logic [9:0]  breath_len;
    logic [9:0]  pos;
    logic [7:0]  level;
    logic        raw;
    logic        run_rise;

    assign run_rise   = run && !run_d_reg;
    assign breath_len = 10'(rate) * 10'h00A;
    assign half_len   = breath_len >> 1;

    // Triangle brightness over the active breath
    always_comb begin
        pos   = (period_reg < half_len) ? period_reg : breath_len - period_reg;
        prod  = 18'(pos) * 18'h000FF;
        level = (breath_len == 10'h000) ? 8'h00 : 8'(prod / 18'(half_len | 10'h001));
    end

    always_comb begin
        unique case (state_reg)
            ibb_pkg::IBB_IDLE:   raw = 1'b0;
            ibb_pkg::IBB_SLEEP:  raw = 1'b0;
            default: begin
                if (breathe)
                    raw = pwm_reg < level;
                else
                    raw = ({1'b0, period_reg[8:0]} * 10'h002) < {4'h0, rate};
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            pwm_reg <= 8'h00;
        else if (clk_en)
            pwm_reg <= pwm_reg + 8'h01;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= ibb_pkg::IBB_IDLE;
            run_d_reg  <= 1'b0;
            first_reg  <= 1'b0;
            period_reg <= 10'h000;
            tail_reg   <= 10'h000;
            pattern    <= 1'b0;
            busy       <= 1'b0;
        end else if (clk_en) begin
            run_d_reg <= run;
            pattern   <= raw ^ invert;
            busy      <= state_reg != ibb_pkg::IBB_IDLE;
            if (run_rise) begin
                state_reg  <= ibb_pkg::IBB_ACTIVE;
                period_reg <= 10'h000;
                first_reg  <= 1'b1;
            end else begin
                unique case (state_reg)
                    ibb_pkg::IBB_IDLE: ;
                    ibb_pkg::IBB_ACTIVE: begin
                        if (!run && breathe) begin
                            state_reg <= ibb_pkg::IBB_IDLE;
                        end else if (!run) begin
                            state_reg <= ibb_pkg::IBB_TAIL;
                            tail_reg  <= 10'h000;
                        end else if (tick && first_reg) begin
                            // Partial first tick skipped, first phase never short
                            first_reg <= 1'b0;
                        end else if (tick) begin
                            if (!breathe && period_reg + 10'h001 >= {4'h0, rate})
                                period_reg <= 10'h000;
                            else if (breathe && period_reg + 10'h001 >= breath_len) begin
                                period_reg <= 10'h000;
                                tail_reg   <= 10'h000;
                                if (tail != 6'h00)
                                    state_reg <= ibb_pkg::IBB_SLEEP;
                            end else
                                period_reg <= period_reg + 10'h001;
                        end
                    end
                    ibb_pkg::IBB_TAIL: begin
                        if (breathe)
                            state_reg <= ibb_pkg::IBB_IDLE;
                        else if (tick) begin
                            if (tail_reg + 10'h001 >= {4'h0, tail})
                                state_reg <= ibb_pkg::IBB_IDLE;
                            else
                                tail_reg <= tail_reg + 10'h001;
                            if (period_reg + 10'h001 >= {4'h0, rate})
                                period_reg <= 10'h000;
                            else
                                period_reg <= period_reg + 10'h001;
                        end
                    end
                    ibb_pkg::IBB_SLEEP: begin
                        if (!run)
                            state_reg <= ibb_pkg::IBB_IDLE;
                        else if (tick) begin
                            if (tail_reg + 10'h001 >= 10'(tail) * 10'h00A)
                                state_reg <= ibb_pkg::IBB_ACTIVE;
                            else
                                tail_reg <= tail_reg + 10'h001;
                        end
                    end
                endcase
            end
        end
    end

endmodule : ibb_channel

// ---- ibb_top.sv ----
`timescale 1ns/1ps
`include "ibb_map.svh"

// Behaviour
// - Polarity bit 7 of control one inverts the indicator output.
// - Bit 6 of control one picks blink (0) or breathe (1).
// - Blink period is rate times 50 ms, high for the first rate/2 ticks rounded up.
// - Breathe duration is rate times 500 ms.
// - Blink tail interval in bits 7:2 of control two, 50 ms steps.
// - Breathe tail field sets dark sleep between breaths, 500 ms steps.
// - Run bit 1 of control two starts the pattern.
// - Pattern timer restarts when run becomes set.
// - In blink mode, clearing run keeps blinking for the tail interval.
// - In breathe mode, clearing run stops at once.
// - Bit 0 of control two gives the pad to general pin or indicator.
// - Sense pull-down bit 0 bus power, bits 1-4 over-current sense.
// - Indicator A pull-down bit 0; bits 7:1 reserved.
// - All these registers reset to 00h.
// - Registers reached with a 16-bit address, upper byte first.
module ibb_top #(
    parameter int unsigned TICK_CYCLES = `IBB_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       clk_en,
    // Configuration access, byte-serial address
    input  wire logic       cfg_addr_hi_wr,
    input  wire logic       cfg_addr_lo_wr,
    input  wire logic [7:0] cfg_addr_byte,
    input  wire logic       cfg_wr,
    input  wire logic       cfg_rd,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    output logic            cfg_rvalid,
    // General-purpose pin data
    input  wire logic       general_pin_a,
    input  wire logic       general_pin_b,
    // Pads
    output logic            indicator_a,
    output logic            indicator_b,
    output logic      [4:0] sense_pulldown_en,
    output logic            indicator_a_pulldown_en
);

    logic [7:0]  addr_hi_reg;
    logic [15:0] addr_reg;
    logic [7:0]  ctl1_reg [2];
    logic [7:0]  ctl2_reg [2];
    logic [4:0]  sense_pd_reg;
    logic        a_pd_reg;
    logic        tick;
    logic [1:0]  pattern;
    logic [1:0]  busy;
    logic [1:0]  gp_pin;

    assign gp_pin = {general_pin_b, general_pin_a};

    ////////////////////////////////////////////////////////////////////////////////
    // Address assembly, upper byte then lower byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_hi_reg <= 8'h00;
            addr_reg    <= 16'h0000;
        end else if (clk_en) begin
            if (cfg_addr_hi_wr)
                addr_hi_reg <= cfg_addr_byte;
            if (cfg_addr_lo_wr)
                addr_reg <= {addr_hi_reg, cfg_addr_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl1_reg[0]  <= `IBB_REG_RESET;
            ctl1_reg[1]  <= `IBB_REG_RESET;
            ctl2_reg[0]  <= `IBB_REG_RESET;
            ctl2_reg[1]  <= `IBB_REG_RESET;
            sense_pd_reg <= 5'h00;
            a_pd_reg     <= 1'b0;
        end else if (clk_en && cfg_wr) begin
            unique case (addr_reg)
                `IBB_ADDR_A_CTL1:   ctl1_reg[0] <= cfg_wdata;
                `IBB_ADDR_A_CTL2:   ctl2_reg[0] <= cfg_wdata;
                `IBB_ADDR_B_CTL1:   ctl1_reg[1] <= cfg_wdata;
                `IBB_ADDR_B_CTL2:   ctl2_reg[1] <= cfg_wdata;
                `IBB_ADDR_SENSE_PD: sense_pd_reg <= cfg_wdata[4:0];
                `IBB_ADDR_A_PD:     a_pd_reg <= cfg_wdata[0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads, reserved bits read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata  <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else if (clk_en) begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                unique case (addr_reg)
                    `IBB_ADDR_A_CTL1:   cfg_rdata <= ctl1_reg[0];
                    `IBB_ADDR_A_CTL2:   cfg_rdata <= ctl2_reg[0];
                    `IBB_ADDR_B_CTL1:   cfg_rdata <= ctl1_reg[1];
                    `IBB_ADDR_B_CTL2:   cfg_rdata <= ctl2_reg[1];
                    `IBB_ADDR_SENSE_PD: cfg_rdata <= {3'h0, sense_pd_reg};
                    `IBB_ADDR_A_PD:     cfg_rdata <= {7'h00, a_pd_reg};
                    default:            cfg_rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timebase
    ibb_prescaler #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_prescaler (
        .clk     (clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Channels
    for (genvar i = 0; i < 2; i++) begin : g_chan
        ibb_channel u_channel (
            .clk     (clk),
            .reset_n (reset_n),
            .clk_en  (clk_en),
            .tick    (tick),
            .breathe (ctl1_reg[i][`IBB_MODE_BIT]),
            .invert  (ctl1_reg[i][`IBB_POL_BIT]),
            .run     (ctl2_reg[i][`IBB_RUN_BIT]),
            .rate    (ctl1_reg[i][`IBB_RATE_MSB:`IBB_RATE_LSB]),
            .tail    (ctl2_reg[i][`IBB_TAIL_MSB:`IBB_TAIL_LSB]),
            .pattern (pattern[i]),
            .busy    (busy[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            indicator_a             <= 1'b0;
            indicator_b             <= 1'b0;
            sense_pulldown_en       <= 5'h00;
            indicator_a_pulldown_en <= 1'b0;
        end else if (clk_en) begin
            indicator_a <= ctl2_reg[0][`IBB_PADSEL_BIT] ? pattern[0] : gp_pin[0];
            indicator_b <= ctl2_reg[1][`IBB_PADSEL_BIT] ? pattern[1] : gp_pin[1];
            sense_pulldown_en       <= sense_pd_reg;
            indicator_a_pulldown_en <= a_pd_reg;
        end
    end

endmodule : ibb_top

// ---- ibb_top_props.sv ----
`timescale 1ns/1ps
`include "ibb_map.svh"

module ibb_top_props #(
    parameter int unsigned TICK_CYCLES = `IBB_TICK_CYCLES
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       clk_en,
    // Configuration access
    input wire logic       cfg_addr_hi_wr,
    input wire logic       cfg_addr_lo_wr,
    input wire logic [7:0] cfg_addr_byte,
    input wire logic       cfg_wr,
    input wire logic       cfg_rd,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic       cfg_rvalid,
    // Pads
    input wire logic       indicator_a,
    input wire logic [4:0] sense_pulldown_en,
    input wire logic       indicator_a_pulldown_en
);
    logic [7:0]  hi_reg;
    logic [15:0] addr_reg;
    logic [7:0]  shadow_reg [6];
    logic [2:0]  slot;
    logic [7:0]  rd_exp;
    logic        wr_take;
    logic        rd_take;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    assign wr_take = clk_en && cfg_wr;
    assign rd_take = clk_en && cfg_rd;
    assign rd_exp  = (slot == 3'h6) ? 8'h00 : shadow_reg[slot];

    always_comb begin
        case (addr_reg)
            `IBB_ADDR_A_CTL1:   slot = 3'h0;
            `IBB_ADDR_A_CTL2:   slot = 3'h1;
            `IBB_ADDR_B_CTL1:   slot = 3'h2;
            `IBB_ADDR_B_CTL2:   slot = 3'h3;
            `IBB_ADDR_SENSE_PD: slot = 3'h4;
            `IBB_ADDR_A_PD:     slot = 3'h5;
            default:            slot = 3'h6;
        endcase
    end

    // Upper byte waits for the lower one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_reg   <= 8'h00;
            addr_reg <= 16'h0000;
        end else if (clk_en) begin
            if (cfg_addr_hi_wr) hi_reg <= cfg_addr_byte;
            if (cfg_addr_lo_wr) addr_reg <= {hi_reg, cfg_addr_byte};
        end
    end

    // Expected contents, reserved bits held at 0
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 6; i++) shadow_reg[i] <= `IBB_REG_RESET;
        end else if (wr_take && slot != 3'h6) begin
            shadow_reg[slot] <= cfg_wdata & ((slot == 3'h4) ? 8'h1F : (slot == 3'h5) ? 8'h01 : 8'hFF);
        end
    end

    sequence read_taken;
        rd_take;
    endsequence

    sequence stay_dark;
        (indicator_a == shadow_reg[0][`IBB_POL_BIT]) [*8];
    endsequence

    sequence breathe_halt;
        wr_take && slot == 3'h1 && !cfg_wdata[`IBB_RUN_BIT] && cfg_wdata[`IBB_PADSEL_BIT]
            && shadow_reg[0][`IBB_MODE_BIT];
    endsequence

    read_pulse_a: assert property (read_taken |=> cfg_rvalid)
        else $error("read gave no valid pulse");
    read_quiet_a: assert property (clk_en && !cfg_rd |=> !cfg_rvalid)
        else $error("valid pulse without read");
    rdata_hold_a: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
        else $error("read data moved without a read");
    read_value_a: assert property (read_taken |=> cfg_rdata == $past(rd_exp))
        else $error("read data differs from register");
    unmapped_read_a: assert property (read_taken and slot == 3'h6 |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    sense_pad_a: assert property (wr_take && slot == 3'h4
        |-> ##2 sense_pulldown_en == $past(cfg_wdata[4:0], 2))
        else $error("sense pull-down pads wrong");
    a_pd_pad_a: assert property (wr_take && slot == 3'h5
        |-> ##2 indicator_a_pulldown_en == $past(cfg_wdata[0], 2))
        else $error("indicator pull-down pad wrong");
    breathe_stop_a: assert property (breathe_halt |-> ##[1:4] stay_dark)
        else $error("breathe did not stop at once");
endmodule : ibb_top_props

bind ibb_top ibb_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cfg_addr_hi_wr(cfg_addr_hi_wr),
    .cfg_addr_lo_wr(cfg_addr_lo_wr), .cfg_addr_byte(cfg_addr_byte), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .indicator_a(indicator_a), .sense_pulldown_en(sense_pulldown_en),
    .indicator_a_pulldown_en(indicator_a_pulldown_en));

// ---- ibb_board.sv ----
`timescale 1ns/1ps

module ibb_board (
    // Clock and window control
    input wire logic        clk,
    input wire logic        clear,
    // Indicator pads
    input wire logic        indicator_a,
    input wire logic        indicator_b,
    // Lit-cycle counts
    output logic     [15:0] lit_a,
    output logic     [15:0] lit_b
);
    // Cycles each indicator is lit since the last clear
    always_ff @(posedge clk) begin
        if (clear) begin
            lit_a <= 16'h0000;
            lit_b <= 16'h0000;
        end else begin
            lit_a <= lit_a + 16'(indicator_a);
            lit_b <= lit_b + 16'(indicator_b);
        end
    end
endmodule : ibb_board

// ---- ibb_top_tb.sv ----
`timescale 1ns/1ps
`include "ibb_map.svh"

module ibb_top_tb;
    localparam int unsigned TICKS = 32;
    logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, clear = 1'b0;
    logic hi_wr = 1'b0, lo_wr = 1'b0, wr = 1'b0, rd = 1'b0, pin_a = 1'b0, pin_b = 1'b0;
    logic [7:0] abyte = 8'h00, wdata = 8'h00, rdata;
    logic rvalid, ind_a, ind_b, apd;
    logic [4:0] spd;
    logic [15:0] lit_a, lit_b, ha, hb;
    int n_errors = 0, compares = 0, cycles = 0;

    ibb_top #(.TICK_CYCLES(TICKS)) uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .cfg_addr_hi_wr(hi_wr), .cfg_addr_lo_wr(lo_wr), .cfg_addr_byte(abyte), .cfg_wr(wr),
        .cfg_rd(rd), .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rvalid(rvalid),
        .general_pin_a(pin_a), .general_pin_b(pin_b), .indicator_a(ind_a),
        .indicator_b(ind_b), .sense_pulldown_en(spd), .indicator_a_pulldown_en(apd));
    ibb_board u_board (.clk(clk), .clear(clear), .indicator_a(ind_a), .indicator_b(ind_b),
        .lit_a(lit_a), .lit_b(lit_b));

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        hi_wr <= 1'b1;
        abyte <= a[15:8];
        @(posedge clk);
        hi_wr <= 1'b0;
        lo_wr <= 1'b1;
        abyte <= a[7:0];
        @(posedge clk);
        lo_wr <= 1'b0;
        wr    <= w;
        rd    <= !w;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask : bus

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(16'(rvalid), 16'h0001);
        chk(16'(rdata), 16'(exp));
    endtask : rd_chk

    // Lit cycles of both pads over n cycles
    task automatic window(input int n);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
        ha = lit_a;
        hb = lit_b;
    endtask : window

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_regs;
        rd_chk(`IBB_ADDR_A_CTL1, 8'h00);
        rd_chk(`IBB_ADDR_A_CTL2, 8'h00);
        rd_chk(`IBB_ADDR_B_CTL1, 8'h00);
        rd_chk(`IBB_ADDR_B_CTL2, 8'h00);
        rd_chk(`IBB_ADDR_SENSE_PD, 8'h00);
        rd_chk(`IBB_ADDR_A_PD, 8'h00);
        bus(16'h0810, 1'b1, 8'hFF);
        rd_chk(16'h0810, 8'h00);
        bus(`IBB_ADDR_B_CTL1, 1'b1, 8'hA5);
        rd_chk(`IBB_ADDR_B_CTL1, 8'hA5);
        bus(`IBB_ADDR_SENSE_PD, 1'b1, 8'hEA);
        rd_chk(`IBB_ADDR_SENSE_PD, 8'h0A);
        chk(16'(spd), 16'h000A);
        bus(`IBB_ADDR_A_PD, 1'b1, 8'hFF);
        rd_chk(`IBB_ADDR_A_PD, 8'h01);
        chk(16'(apd), 16'h0001);
        $display("test regs done");
    endtask : test_regs

    task automatic test_pads;
        @(posedge clk);
        pin_a <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(16'({ind_a, ind_b}), 16'h0002);
        bus(`IBB_ADDR_A_CTL1, 1'b1, 8'h80);
        bus(`IBB_ADDR_A_CTL2, 1'b1, 8'h01);
        @(posedge clk);
        pin_b <= 1'b1;
        pin_a <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(16'({ind_a, ind_b}), 16'h0003);
        $display("test pads done");
    endtask : test_pads

    task automatic test_blink;
        bus(`IBB_ADDR_A_CTL1, 1'b1, 8'h04);
        bus(`IBB_ADDR_B_CTL1, 1'b1, 8'h02);
        bus(`IBB_ADDR_B_CTL2, 1'b1, 8'h03);
        bus(`IBB_ADDR_A_CTL2, 1'b1, 8'h03);
        // First high phase runs at least two whole ticks
        window(60);
        chk(ha, 16'd59);
        window(256);
        chk(ha, 16'd128);
        chk(hb, 16'd128);
        bus(`IBB_ADDR_A_CTL2, 1'b1, 8'h21);
        window(128);
        chk(ha, 16'd64);
        repeat (200) @(posedge clk);
        window(128);
        chk(ha, 16'd0);
        $display("test blink done");
    endtask : test_blink

    task automatic test_breathe;
        bus(`IBB_ADDR_B_CTL2, 1'b1, 8'h00);
        bus(`IBB_ADDR_A_CTL1, 1'b1, 8'h41);
        bus(`IBB_ADDR_A_CTL2, 1'b1, 8'h07);
        window(256);
        chk(16'(ha > 0 && ha < 256), 16'h0001);
        // Ten-tick breath, then ten dark ticks of sleep
        repeat (98) @(posedge clk);
        window(256);
        chk(ha, 16'd0);
        window(256);
        chk(16'(ha > 0), 16'h0001);
        bus(`IBB_ADDR_A_CTL2, 1'b1, 8'h05);
        repeat (4) @(posedge clk);
        window(64);
        chk(ha, 16'd0);
        $display("test breathe done");
    endtask : test_breathe

    task automatic test_freeze;
        @(posedge clk);
        clk_en <= 1'b0;
        pin_b  <= 1'b0;
        bus(`IBB_ADDR_SENSE_PD, 1'b1, 8'h15);
        chk(16'({ind_b, spd}), 16'h002A);
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(16'({ind_b, spd}), 16'h000A);
        rd_chk(`IBB_ADDR_SENSE_PD, 8'h0A);
        $display("test freeze done");
    endtask : test_freeze

    task automatic test_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(`IBB_ADDR_SENSE_PD, 8'h00);
        rd_chk(`IBB_ADDR_A_CTL1, 8'h00);
        chk(16'({ind_a, spd, apd}), 16'h0000);
        $display("test reset done");
    endtask : test_reset

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        test_regs();
        test_pads();
        test_blink();
        test_breathe();
        test_freeze();
        test_reset();
        print_verdict();
    end
endmodule : ibb_top_tb
